// File: core/msrs_seq.v
/*
 multi-step reference sequencer: sixteen signed steps with durations and ramp-set
 selectors, end-of-cycle modes, retention on stop and on power loss, register port.
 assumes run_cmd and stop_cmd are pins (synchronised here) and that a power-loss
 snapshot is kept by the caller in non-volatile storage and presented at power-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrs_defs.vh"

// Behaviour
// RL1 - mode 0: halt after last step, idle until a new run command
// RL2 - mode 1: hold final step value and direction after the cycle
// RL3 - mode 2: wrap to step 0 and loop until stop
// RL4 - frequency route: negative reference means reverse, otherwise forward
// RL5 - output routed to frequency setpoint or separated voltage setpoint
// RL6 - power retention on: resume saved step, time, output at power-up
// RL7 - stop retention on: resume from stopped point at next start
// RL8 - retention defaults to both disabled
// RL9 - per-step duration 0.0 to 6553.5 units, 0.1 resolution, default 0; with hours the code counts whole hours
// RL10 - per-step two-bit ramp-set selector, default set 0
// RL11 - end-of-cycle mode accepts only 0, 1, 2
// RL12 - references signed -100.0% to 100.0% in 0.1% steps
// RL13 - one unit selector: seconds when 0, hours when 1
// RL14 - advance when elapsed reaches duration; cycle ends after last step
// RL15 - steps with zero duration are skipped at once
module msrs_seq #(
   parameter integer STEPS        = 16,
   parameter integer TENTH_CYCLES = `MSRS_CLK_HZ / 1000 * `MSRS_TENTH_SEC_MS
) (
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata_ff,
   input  wire        run_cmd,
   input  wire        stop_cmd,
   input  wire        pwr_restore,
   input  wire [3:0]  pwr_step,
   input  wire [15:0] pwr_elapsed,
   input  wire [15:0] pwr_output,
   output reg  [3:0]  snap_step_ff,
   output reg  [15:0] snap_elapsed_ff,
   output reg  [15:0] snap_output_ff,
   output reg  [15:0] freq_ref_ff,
   output reg  [15:0] volt_ref_ff,
   output reg         reverse_ff,
   output reg  [1:0]  ramp_set_ff,
   output reg         drive_run_ff
);

   // ==============================================================
   // state
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_RUN  = 4'b0010;
   localparam [3:0] ST_HOLD = 4'b0100;
   localparam [3:0] ST_DONE = 4'b1000;

   reg  [3:0]  state_ff;
   reg  [3:0]  nxt_state;
   reg  [3:0]  step_ff;
   reg  [3:0]  nxt_step;
   reg  [15:0] elapsed_ff;
   reg  [15:0] nxt_elapsed;
   reg  [15:0] out_ff;
   reg  [15:0] nxt_out;
   reg  [1:0]  mode_ff;
   reg         pwr_ret_ff;
   reg         stop_ret_ff;
   reg         unit_ff;
   reg         route_ff;
   reg         pwr_done_ff;
   reg         resume_ff;
   reg  [15:0] ref_mem [0:STEPS-1];
   reg  [15:0] dur_mem [0:STEPS-1];
   reg  [1:0]  ramp_mem [0:STEPS-1];
   wire        run_s;
   wire        stop_s;
   reg         run_d_ff;
   wire        run_rise;
   wire        tick;
   wire        last_step;
   wire        step_end;
   wire [15:0] wr_ref;
   wire        wr_ctrl;

   // ==============================================================
   // command pin synchronisers
   msrs_sync u_run_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .din     (run_cmd),
      .dout_ff (run_s)
   );

   msrs_sync u_stop_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .din     (stop_cmd),
      .dout_ff (stop_s)
   );

   // time base, tick every 0.1 s, or every 1 h when hours are selected
   msrs_tick #(
      .TENTH_CYCLES (TENTH_CYCLES)
   ) u_tick (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .enable    (state_ff == ST_RUN),
      .unit_hour (unit_ff), // see RL13
      .tick_ff   (tick)
   );

   // ==============================================================
   // register writes
   assign wr_ctrl = reg_wr && (reg_addr == `MSRS_REG_CTRL);
   // clamp to +-100.0%
   assign wr_ref  = ($signed(reg_wdata[15:0]) > `MSRS_REF_MAX) ? `MSRS_REF_MAX :
                    ($signed(reg_wdata[15:0]) < `MSRS_REF_MIN) ? `MSRS_REF_MIN :
                    reg_wdata[15:0]; // see RL12

   // control fields
   always @(posedge ref_clk) begin
      if (!resetn) begin
         mode_ff     <= `MSRS_MODE_RST;
         pwr_ret_ff  <= `MSRS_RET_RST; // see RL8
         stop_ret_ff <= `MSRS_RET_RST; // see RL8
         unit_ff     <= `MSRS_UNIT_SEC;
         route_ff    <= `MSRS_ROUTE_FREQ;
      end else if (wr_ctrl) begin
         if (reg_wdata[`MSRS_CTRL_MODE_MSB:`MSRS_CTRL_MODE_LSB] != 2'h3) begin
            mode_ff <= reg_wdata[`MSRS_CTRL_MODE_MSB:`MSRS_CTRL_MODE_LSB]; // see RL11
         end
         pwr_ret_ff  <= reg_wdata[`MSRS_CTRL_PWR_RET];
         stop_ret_ff <= reg_wdata[`MSRS_CTRL_STOP_RET];
         unit_ff     <= reg_wdata[`MSRS_CTRL_UNIT];
         route_ff    <= reg_wdata[`MSRS_CTRL_ROUTE];
      end
   end

   // per-step tables, one entry per generate pass
   genvar gi;
   generate
      for (gi = 0; gi < STEPS; gi = gi + 1) begin : g_step
         always @(posedge ref_clk) begin
            if (!resetn) begin
               ref_mem[gi]  <= 16'h0000;
               dur_mem[gi]  <= 16'h0000; // see RL9
               ramp_mem[gi] <= 2'h0; // see RL10
            end else if (reg_wr) begin
               if (reg_addr == `MSRS_REG_REF_BASE + gi) begin
                  ref_mem[gi] <= wr_ref;
               end
               if (reg_addr == `MSRS_REG_DUR_BASE + gi) begin
                  dur_mem[gi] <= reg_wdata[15:0]; // see RL9
               end
               if (reg_addr == `MSRS_REG_RAMP_BASE + gi) begin
                  ramp_mem[gi] <= reg_wdata[1:0]; // see RL10
               end
            end
         end
      end
   endgenerate

   // register reads, data in the following cycle
   always @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata_ff <= 32'h00000000;
      end else if (reg_rd) begin
         if (reg_addr == `MSRS_REG_CTRL) begin
            reg_rdata_ff <= {22'h000000, route_ff, unit_ff, 2'h0, stop_ret_ff, pwr_ret_ff,
                             2'h0, mode_ff};
         end else if (reg_addr == `MSRS_REG_STATUS) begin
            reg_rdata_ff <= {20'h00000, step_ff, 4'h0, state_ff};
         end else if (reg_addr == `MSRS_REG_OUTPUT) begin
            reg_rdata_ff <= {16'h0000, out_ff};
         end else if (reg_addr == `MSRS_REG_ELAPSED) begin
            reg_rdata_ff <= {16'h0000, elapsed_ff};
         end else if (reg_addr[7:4] == 4'h1) begin
            reg_rdata_ff <= {16'h0000, ref_mem[reg_addr[3:0]]};
         end else if (reg_addr[7:4] == 4'h2) begin
            reg_rdata_ff <= {16'h0000, dur_mem[reg_addr[3:0]]};
         end else if (reg_addr[7:4] == 4'h3) begin
            reg_rdata_ff <= {30'h00000000, ramp_mem[reg_addr[3:0]]};
         end else begin
            reg_rdata_ff <= 32'h00000000; // unmapped reads zero
         end
      end else begin
         reg_rdata_ff <= 32'h00000000;
      end
   end

   // ==============================================================
   // sequencing
   assign run_rise  = run_s && !run_d_ff;
   assign last_step = (step_ff == STEPS[3:0] - 4'h1);
   // zero duration ends the step at once
   assign step_end  = (dur_mem[step_ff] == 16'h0000) ||
                      (tick && (elapsed_ff + 16'h0001 >= dur_mem[step_ff])); // see RL14 RL15

   // next-state logic
   always @* begin
      nxt_state   = state_ff;
      nxt_step    = step_ff;
      nxt_elapsed = elapsed_ff;
      nxt_out     = out_ff;
      case (state_ff)
         ST_IDLE, ST_DONE: begin
            if (run_rise && !stop_s) begin
               nxt_state = ST_RUN;
               if (!stop_ret_ff && !resume_ff) begin // see RL6 RL7
                  nxt_step    = 4'h0;
                  nxt_elapsed = 16'h0000;
               end
               nxt_out = ref_mem[nxt_step];
            end
         end
         ST_RUN: begin
            // while running, a zero-duration step never updates the output
            if (dur_mem[step_ff] != 16'h0000) begin
               nxt_out = ref_mem[step_ff]; // see RL15
            end
            if (stop_s) begin
               nxt_state = ST_IDLE;
            end else if (step_end) begin
               nxt_elapsed = 16'h0000;
               if (!last_step) begin
                  nxt_step = step_ff + 4'h1; // see RL14
               end else begin
                  case (mode_ff)
                     `MSRS_MODE_HOLD: nxt_state = ST_HOLD; // see RL2
                     `MSRS_MODE_REPEAT: nxt_step = 4'h0; // see RL3
                     default: begin
                        nxt_state = ST_DONE; // see RL1
                        nxt_step  = 4'h0;
                     end
                  endcase
               end
            end else if (tick) begin
               nxt_elapsed = elapsed_ff + 16'h0001;
            end
         end
         ST_HOLD: begin
            if (stop_s) begin
               nxt_state = ST_IDLE;
               nxt_step  = 4'h0;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // state registers, power-up resume on first restore strobe
   always @(posedge ref_clk) begin
      if (!resetn) begin
         state_ff    <= ST_IDLE;
         step_ff     <= 4'h0;
         elapsed_ff  <= 16'h0000;
         out_ff      <= 16'h0000;
         run_d_ff    <= 1'b0;
         pwr_done_ff <= 1'b0;
         resume_ff   <= 1'b0;
      end else begin
         run_d_ff <= run_s;
         if (pwr_restore && !pwr_done_ff) begin
            pwr_done_ff <= 1'b1;
            if (pwr_ret_ff) begin // see RL6
               resume_ff  <= 1'b1;
               step_ff    <= pwr_step;
               elapsed_ff <= pwr_elapsed;
               out_ff     <= pwr_output;
            end
         end else begin
            state_ff   <= nxt_state;
            step_ff    <= nxt_step;
            elapsed_ff <= nxt_elapsed;
            out_ff     <= nxt_out;
            if (state_ff == ST_RUN) begin
               resume_ff <= 1'b0; // restored position used once
            end
         end
      end
   end

   // ==============================================================
   // outputs and power-loss snapshot
   always @(posedge ref_clk) begin
      if (!resetn) begin
         freq_ref_ff     <= 16'h0000;
         volt_ref_ff     <= 16'h0000;
         reverse_ff      <= 1'b0;
         ramp_set_ff     <= 2'h0;
         drive_run_ff    <= 1'b0;
         snap_step_ff    <= 4'h0;
         snap_elapsed_ff <= 16'h0000;
         snap_output_ff  <= 16'h0000;
      end else begin
         drive_run_ff <= (state_ff == ST_RUN) || (state_ff == ST_HOLD); // see RL1 RL2
         // while running, zero-duration steps leave the ramp selection alone
         if ((state_ff != ST_RUN) || (dur_mem[step_ff] != 16'h0000)) begin
            ramp_set_ff <= ramp_mem[step_ff]; // see RL10 RL15
         end
         if (route_ff == `MSRS_ROUTE_FREQ) begin // see RL5
            freq_ref_ff <= out_ff;
            volt_ref_ff <= 16'h0000;
            reverse_ff  <= out_ff[15]; // see RL4
         end else begin
            freq_ref_ff <= 16'h0000;
            volt_ref_ff <= out_ff;
            reverse_ff  <= 1'b0;
         end
         // snapshot only meaningful when power retention is on
         if (pwr_ret_ff) begin // see RL6
            snap_step_ff    <= step_ff;
            snap_elapsed_ff <= elapsed_ff;
            snap_output_ff  <= out_ff;
         end else begin
            snap_step_ff    <= 4'h0;
            snap_elapsed_ff <= 16'h0000;
            snap_output_ff  <= 16'h0000;
         end
      end
   end

endmodule // msrs_seq

`default_nettype wire

// File: core/msrs_defs.vh
/*
 constants for the multi-step reference sequencer: register offsets, field positions,
 reset values, encodings and timing counts.
 assumes inclusion by bare name from the core design files.
*/
`ifndef MSRS_DEFS_VH
`define MSRS_DEFS_VH

// ==============================================================
// register offsets (word index on the plain register port)
`define MSRS_REG_CTRL        8'h00
`define MSRS_REG_STATUS      8'h01
`define MSRS_REG_OUTPUT      8'h02
`define MSRS_REG_ELAPSED     8'h03
`define MSRS_REG_REF_BASE    8'h10
`define MSRS_REG_DUR_BASE    8'h20
`define MSRS_REG_RAMP_BASE   8'h30

// ==============================================================
// control register fields
`define MSRS_CTRL_MODE_LSB   0
`define MSRS_CTRL_MODE_MSB   1
`define MSRS_CTRL_PWR_RET    4
`define MSRS_CTRL_STOP_RET   5
`define MSRS_CTRL_UNIT       8
`define MSRS_CTRL_ROUTE      9

// ==============================================================
// encodings and reset values
`define MSRS_MODE_STOP       2'h0
`define MSRS_MODE_HOLD       2'h1
`define MSRS_MODE_REPEAT     2'h2
`define MSRS_MODE_RST        2'h0
`define MSRS_RET_RST         1'b0
`define MSRS_UNIT_SEC        1'b0
`define MSRS_UNIT_HOUR       1'b1
`define MSRS_ROUTE_FREQ      1'b0
`define MSRS_ROUTE_VOLT      1'b1
`define MSRS_REF_MAX         16'sh03E8
`define MSRS_REF_MIN         -16'sh03E8

// ==============================================================
// timing: duration lsb is 0.1 s, or 1 h when the hour unit is selected
`define MSRS_CLK_HZ          25000000
`define MSRS_TENTH_SEC_MS    100
`define MSRS_TENTHS_PER_HOUR 36000

`endif

// File: core/msrs_tick.v
/*
 tick generator: divides ref_clk to 0.1 s pulses, and further
 to 1 h pulses (36000 of the 0.1 s pulses) when hours are selected.
 assumes a free running ref_clk and a synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msrs_defs.vh"

module msrs_tick #(
   parameter integer TENTH_CYCLES = `MSRS_CLK_HZ / 1000 * `MSRS_TENTH_SEC_MS,
   parameter integer HOUR_TENTHS  = `MSRS_TENTHS_PER_HOUR
) (
   input  wire ref_clk,
   input  wire resetn,
   input  wire enable,
   input  wire unit_hour,
   output reg  tick_ff
);

   reg [23:0] pre_ff;
   reg [15:0] hr_ff;
   wire       sec_tick;

   assign sec_tick = enable && (pre_ff == TENTH_CYCLES[23:0] - 24'h000001);

   // prescaler and hour divider
   always @(posedge ref_clk) begin
      if (!resetn || !enable) begin
         pre_ff  <= 24'h000000;
         hr_ff   <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         pre_ff  <= sec_tick ? 24'h000000 : pre_ff + 24'h000001;
         tick_ff <= 1'b0;
         if (sec_tick) begin
            if (unit_hour == `MSRS_UNIT_HOUR) begin
               if (hr_ff == HOUR_TENTHS[15:0] - 16'h0001) begin
                  hr_ff   <= 16'h0000;
                  tick_ff <= 1'b1;
               end else begin
                  hr_ff <= hr_ff + 16'h0001;
               end
            end else begin
               tick_ff <= 1'b1;
            end
         end
      end
   end

endmodule // msrs_tick

`default_nettype wire

// File: core/msrs_sync.v
/*
 three flip-flop input synchroniser; a change counts once stages two and three agree.
 assumes an asynchronous level input and one ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module msrs_sync (
   input  wire ref_clk,
   input  wire resetn,
   input  wire din,
   output reg  dout_ff
);

   reg s1_ff;
   reg s2_ff;
   reg s3_ff;

   // shift chain, output updates only on agreement
   always @(posedge ref_clk) begin
      if (!resetn) begin
         s1_ff   <= 1'b0;
         s2_ff   <= 1'b0;
         s3_ff   <= 1'b0;
         dout_ff <= 1'b0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            dout_ff <= s3_ff;
         end
      end
   end

endmodule // msrs_sync

`default_nettype wire

// File: testbench/msrs_seq_checker.sv
/*
 checker: port assertions for the multi-step reference sequencer.
 assumes a bind from the bench top and one ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module msrs_seq_checker (
   input wire        ref_clk,
   input wire        resetn,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata_ff,
   input wire        stop_cmd,
   input wire [3:0]  snap_step_ff,
   input wire [15:0] freq_ref_ff,
   input wire [15:0] volt_ref_ff,
   input wire        reverse_ff,
   input wire        drive_run_ff
);
   // ==========================================
   // shadow of the control word
   reg [9:0] ctrl_ff;
   always @(posedge ref_clk)
      if (!resetn) ctrl_ff <= 10'h000;
      else if (reg_wr && reg_addr == 8'h00) begin
         ctrl_ff[9:2] <= reg_wdata[9:2];
         if (reg_wdata[1:0] != 2'h3) ctrl_ff[1:0] <= reg_wdata[1:0];
      end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // properties
   property p_rev_neg; reverse_ff |-> freq_ref_ff[15]; endproperty
   a_rev_neg: assert property (p_rev_neg) else $error("reverse without negative");
   property p_neg_rev; freq_ref_ff[15] |-> reverse_ff; endproperty
   a_neg_rev: assert property (p_neg_rev) else $error("negative without reverse");
   property p_range;
      $signed(freq_ref_ff) <= $signed(16'h03E8) && $signed(freq_ref_ff) >= $signed(16'hFC18);
   endproperty
   a_range: assert property (p_range) else $error("frequency out of range");
   property p_stop; stop_cmd [*8] |-> ##2 !drive_run_ff; endproperty
   a_stop: assert property (p_stop) else $error("still driving after stop");
   property p_snap; !ctrl_ff[4] && !$past(ctrl_ff[4]) |-> snap_step_ff == 4'h0; endproperty
   a_snap: assert property (p_snap) else $error("snapshot with retention off");
   property p_volt; ctrl_ff[9] && $past(ctrl_ff[9]) |-> freq_ref_ff == 16'h0000; endproperty
   a_volt: assert property (p_volt) else $error("frequency on voltage route");
   property p_freq; !ctrl_ff[9] && !$past(ctrl_ff[9]) |-> volt_ref_ff == 16'h0000; endproperty
   a_freq: assert property (p_freq) else $error("voltage on frequency route");
   property p_refuse;
      (reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'h3) ##2 (reg_rd && reg_addr == 8'h00)
         |=> reg_rdata_ff[1:0] != 2'h3;
   endproperty
   a_refuse: assert property (p_refuse) else $error("mode 3 accepted");
endmodule // msrs_seq_checker
`default_nettype wire

// File: testbench/msrs_nvstore.sv
/*
 partner: non-volatile snapshot store beside the drive.
 assumes the bench pulses save one cycle at power loss.
*/
`timescale 1ns/1ps
`default_nettype none
module msrs_nvstore (
   input  wire        ref_clk,
   input  wire        save,
   input  wire [3:0]  snap_step,
   input  wire [15:0] snap_elapsed,
   input  wire [15:0] snap_output,
   output logic [3:0]  pwr_step,
   output logic [15:0] pwr_elapsed,
   output logic [15:0] pwr_output
);
   // blank store reads as all ones
   initial {pwr_step, pwr_elapsed, pwr_output} = {36{1'b1}};
   // capture the live snapshot on save
   always @(posedge ref_clk)
      if (save) {pwr_step, pwr_elapsed, pwr_output} <= {snap_step, snap_elapsed, snap_output};
endmodule // msrs_nvstore
`default_nettype wire

// File: testbench/multi_step_reference_sequencer_test.sv
/*
 bench: step model, register, mode and retention scenarios.
 assumes the sequencer core, the checker and the store model.
*/
`timescale 1ns/1ps
`default_nettype none
module multi_step_reference_sequencer_test;
   logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
   logic run_cmd = 0, stop_cmd = 0, pwr_restore = 0, save = 0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000, rd;
   wire [31:0] reg_rdata_ff;
   wire [3:0] pwr_step, snap_step_ff;
   wire [15:0] pwr_elapsed, pwr_output, snap_elapsed_ff, snap_output_ff, freq_ref_ff, volt_ref_ff;
   wire reverse_ff, drive_run_ff;
   wire [1:0] ramp_set_ff;
   int failures = 0, compares = 0, ref_v[16], dur_v[16], q[$];
   always #20 ref_clk = ~ref_clk;
   msrs_seq #(.STEPS(16), .TENTH_CYCLES(10)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff), .run_cmd(run_cmd), .stop_cmd(stop_cmd),
      .pwr_restore(pwr_restore), .pwr_step(pwr_step), .pwr_elapsed(pwr_elapsed),
      .pwr_output(pwr_output), .snap_step_ff(snap_step_ff), .snap_elapsed_ff(snap_elapsed_ff),
      .snap_output_ff(snap_output_ff), .freq_ref_ff(freq_ref_ff), .volt_ref_ff(volt_ref_ff),
      .reverse_ff(reverse_ff), .ramp_set_ff(ramp_set_ff), .drive_run_ff(drive_run_ff));
   msrs_nvstore i_store (.ref_clk(ref_clk), .save(save), .snap_step(snap_step_ff),
      .snap_elapsed(snap_elapsed_ff), .snap_output(snap_output_ff), .pwr_step(pwr_step),
      .pwr_elapsed(pwr_elapsed), .pwr_output(pwr_output));
   // ==========================================
   // tasks
   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      chk_reg({16'h0000, got}, {16'h0000, exp});
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rd = reg_rdata_ff;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // run or stop pin held eight cycles
   task automatic pin(input bit run);
      @(posedge ref_clk);
      if (run) run_cmd <= 1'b1;
      else stop_cmd <= 1'b1;
      repeat (8) @(posedge ref_clk);
      run_cmd <= 1'b0;
      stop_cmd <= 1'b0;
      cyc(run ? 1 : 8);
   endtask
   task automatic wait_run(input logic want);
      int n;
      for (n = 0; n < 200 && drive_run_ff !== want; n++) cyc(1);
      if (n == 200) begin
         chk_out(drive_run_ff, want);
         end_of_test();
      end
   endtask
   task automatic wait_step(input int k, input bit volt);
      logic [15:0] e;
      int n;
      e = 16'(ref_v[k]);
      for (n = 0; n < 600 && (volt ? volt_ref_ff : freq_ref_ff) !== e; n++) cyc(1);
      if (n == 600) begin
         chk_out(volt ? volt_ref_ff : freq_ref_ff, e);
         end_of_test();
      end
      cyc(1);
      chk_out(ramp_set_ff, k == 0 ? 16'h0001 : k == 2 ? 16'h0002 : 16'h0003);
      if (!volt) chk_out(reverse_ff, ref_v[k] < 0);
   endtask
   task automatic prog;
      for (int k = 0; k < 16; k++) begin
         bus(1, 8'(16 + k), 32'(ref_v[k]));
         bus(1, 8'(32 + k), 32'(dur_v[k]));
         bus(1, 8'(48 + k), k == 0 ? 32'h1 : k == 2 ? 32'h2 : 32'h3);
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(95));
      foreach (ref_v[k]) ref_v[k] = int'($urandom_range(1000, 1)) * ($urandom_range(1) ? 1 : -1);
      ref_v[15] = -int'($urandom_range(1000, 1));
      dur_v = '{4, 0, 3, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3};
      foreach (dur_v[k]) if (dur_v[k] != 0) q.push_back(k);
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      bus(0, 8'h00, 0); chk_reg(rd, 32'h0);
      bus(0, 8'h25, 0); chk_reg(rd, 32'h0);
      bus(0, 8'h35, 0); chk_reg(rd, 32'h0);
      bus(1, 8'h00, 1); bus(1, 8'h00, 3); bus(0, 8'h00, 0); chk_reg(rd, 32'h1);
      bus(1, 8'h13, 32'h7D0); bus(0, 8'h13, 0); chk_out(rd[15:0], 16'h03E8);
      bus(1, 8'h13, 32'hF830); bus(0, 8'h13, 0); chk_out(rd[15:0], 16'hFC18);
      bus(1, 8'h23, 32'hFFFF); bus(0, 8'h23, 0); chk_reg(rd, 32'h0000FFFF);
      bus(0, 8'h0F, 0); chk_reg(rd, 32'h0);
      $display("test registers done");
      prog();
      for (int m = 0; m < 3; m++) begin
         bus(1, 8'h00, m == 2 ? 32'h202 : 32'(m));
         pin(1);
         foreach (q[i]) wait_step(q[i], m == 2);
         if (m == 0) begin
            wait_run(0); bus(0, 8'h01, 0); chk_out(rd[3:0], 16'h8);
         end else if (m == 1) begin
            cyc(80); chk_out(drive_run_ff, 1);
            chk_out(freq_ref_ff, 16'(ref_v[15]));
         end else begin
            wait_step(0, 1); chk_out(freq_ref_ff, 16'h0);
         end
         pin(0);
         wait_run(0);
         $display("test mode %0d done", m);
      end
      for (int r = 0; r < 2; r++) begin
         bus(1, 8'h00, 32'(r) << 5); pin(1); wait_step(2, 0); pin(0); pin(1); wait_run(1);
         bus(0, 8'h01, 0); chk_out(rd[11:8], r ? 16'h2 : 16'h0);
         pin(0); wait_run(0);
         $display("test stop retention %0d done", r);
      end
      bus(1, 8'h00, 32'h100); pin(1); cyc(60);
      bus(0, 8'h01, 0); chk_out(rd[11:8], 16'h0);
      pin(0); wait_run(0);
      $display("test hour unit done");
      bus(1, 8'h00, 32'h10); pin(1); wait_step(2, 0);
      @(posedge ref_clk);
      save <= 1'b1;
      @(posedge ref_clk);
      save <= 1'b0;
      cyc(1);
      chk_out(pwr_step, 16'h2);
      chk_out(pwr_output, 16'(ref_v[2]));
      pin(0);
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      prog();
      bus(1, 8'h00, 32'h10);
      @(posedge ref_clk);
      pwr_restore <= 1'b1;
      @(posedge ref_clk);
      pwr_restore <= 1'b0;
      pin(1); bus(0, 8'h01, 0); chk_out(rd[11:8], 16'h2);
      pin(0);
      $display("test power retention done");
      end_of_test();
   end
endmodule // multi_step_reference_sequencer_test
bind msrs_seq msrs_seq_checker i_chk (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .stop_cmd(stop_cmd), .snap_step_ff(snap_step_ff), .freq_ref_ff(freq_ref_ff),
   .volt_ref_ff(volt_ref_ff), .reverse_ff(reverse_ff), .drive_run_ff(drive_run_ff));
`default_nettype wire
